// >>> vpic_top.sv
// Purpose: vectored, maskable, eight-level interrupt controller
// Assumes: single free-running clock, sources synchronous to it
// Notes: registers reached over classic wishbone, ack one cycle late
//   wb_sel_i is ignored: every access is a whole word
`timescale 1ns/10ps
`default_nettype none
module vpic_top
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // interrupt sources
  input wire logic fast_request_input,
  input wire logic [vpic_pkg::vpic_nsys-1:0] system_lines,
  input wire logic [vpic_pkg::vpic_nsrc-1:2] external_request_inputs,
  // processor side
  output logic normal_request_out_n,
  output logic fast_request_out_n,
  output logic wake_out,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  localparam int unsigned n = vpic_pkg::vpic_nsrc;

  // per-source configuration
  logic [2:0] pri_field [n];
  logic [1:0] trigger_type_field [n];
  logic [31:0] source_vector_reg [n];
  // mask, force and general mask
  logic [n-1:0] mask_reg;
  logic [n-1:0] force_reg;
  logic gmask;
  // source sampling and edge memory
  logic [n-1:0] src_now;
  logic [n-1:0] src_prev;
  logic [n-1:0] edge_mem;
  logic [n-1:0] is_edge;
  logic [n-1:0] edge_hit;
  logic [n-1:0] level_hit;
  logic [n-1:0] pending;
  // nesting stack
  localparam int unsigned vpic_depth_arr = vpic_pkg::vpic_depth;
  logic [4:0] stk_num [vpic_depth_arr];
  logic [2:0] stk_pri [vpic_depth_arr];
  logic [3:0] depth;
  // resolver results
  logic best_valid;
  logic [4:0] best_num;
  logic [2:0] best_pri;
  logic normal_cond;
  logic fast_cond;
  logic [4:0] cur_num;
  logic [2:0] cur_pri;
  // bus decode
  logic take;
  logic rd_take;
  logic wr_take;
  logic rd_normal;
  logic rd_fast;
  logic wr_eos;
  logic do_push; // vector read that pushes
  logic [31:0] next_rdata;

  // true when the request hits the given register word
  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    hit = (a[9:2] == r[9:2]);
  endfunction

  // true when the request falls in a 32-word array region
  function automatic logic in_region(input logic [9:0] a,
                                     input logic [9:0] base);
    in_region = (a[9:7] == base[9:7]);
  endfunction

  // a request is taken once, in the cycle before ack
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rd_take = take & ~wb_we_i;
  assign wr_take = take & wb_we_i;
  assign rd_normal = rd_take & hit(wb_adr_i, vpic_pkg::vpic_normal_vector);
  assign rd_fast = rd_take & hit(wb_adr_i, vpic_pkg::vpic_fast_vector);
  assign wr_eos = wr_take & hit(wb_adr_i, vpic_pkg::vpic_end_of_service);
  // a vector read pushes and clears only when a source is eligible;
  // a full stack refuses the push and therefore the clear as well
  assign do_push = rd_normal & normal_cond &
                   (depth != vpic_pkg::vpic_depth_full);

  // source vector: fast pin, OR of system lines, peripherals and pins
  // pin routing is sampled on the same path as peripherals
  assign src_now = {external_request_inputs,
                    |system_lines,
                    fast_request_input};

  // delayed copy for edge detection
  // zero after reset: an input already high reads as a rising edge
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      src_prev <= vpic_pkg::vpic_word_zero;
    else
      src_prev <= src_now;
  end

  // condition detection per source, chosen by its trigger type
  // all four codes are legal, so the case needs no default
  for (genvar i = 0; i < n; i++)
  begin : g_detect
    always_comb
    begin
      is_edge[i] = 1'b0;
      edge_hit[i] = 1'b0;
      level_hit[i] = 1'b0;
      unique case (vpic_pkg::vpic_trig_t'(trigger_type_field[i]))
        vpic_pkg::vpic_trig_low:
          level_hit[i] = ~src_now[i];
        vpic_pkg::vpic_trig_high:
          level_hit[i] = src_now[i];
        vpic_pkg::vpic_trig_fall:
        begin
          is_edge[i] = 1'b1;
          edge_hit[i] = src_prev[i] & ~src_now[i];
        end
        vpic_pkg::vpic_trig_rise:
        begin
          is_edge[i] = 1'b1;
          edge_hit[i] = ~src_prev[i] & src_now[i];
        end
      endcase
    end
  end

  // edge memory: commands only touch edge sources, set beats clear
  // set wins so that an edge landing on a clear is never lost
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      edge_mem <= vpic_pkg::vpic_word_zero;
    else
    begin
      for (int i = 0; i < n; i++)
      begin
        logic clr;
        logic set;
        clr = 1'b0;
        set = edge_hit[i];
        // software clear command
        if (wr_take & hit(wb_adr_i, vpic_pkg::vpic_clear_cmd) &
            wb_dat_i[i])
          clr = 1'b1;
        // software set command, e.g. a software interrupt
        if (wr_take & hit(wb_adr_i, vpic_pkg::vpic_set_cmd) & wb_dat_i[i])
          set = 1'b1;
        // automatic clear of the chosen source on a vector read
        if (do_push & (best_num == 5'(i)) & ~force_reg[i])
          clr = 1'b1;
        // fast vector read clears source zero
        if (rd_fast & (i == 0))
          clr = 1'b1;
        if (!is_edge[i])
          edge_mem[i] <= 1'b0;
        else if (set)
          edge_mem[i] <= 1'b1;
        else if (clr)
          edge_mem[i] <= 1'b0;
      end
    end
  end

  // pending: level condition or held edge, independent of mask
  assign pending = level_hit | (edge_mem & is_edge);

  // mask register via enable and disable commands
  // bit-wise commands: no read-modify-write race with other masters
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      mask_reg <= vpic_pkg::vpic_word_zero;
    else if (wr_take & hit(wb_adr_i, vpic_pkg::vpic_enable_cmd))
      mask_reg <= mask_reg | wb_dat_i;
    else if (wr_take & hit(wb_adr_i, vpic_pkg::vpic_disable_cmd))
      mask_reg <= mask_reg & ~wb_dat_i;
  end

  // fast forcing register; source zero is always fast anyway
  // a forced source leaves the resolver and feeds the fast line
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      force_reg <= vpic_pkg::vpic_word_zero;
    else if (wr_take & hit(wb_adr_i, vpic_pkg::vpic_force_enable))
      force_reg <= force_reg | wb_dat_i;
    else if (wr_take & hit(wb_adr_i, vpic_pkg::vpic_force_disable))
      force_reg <= force_reg & ~wb_dat_i;
  end

  // general mask control
  // only the request lines obey it; wake still follows conditions
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      gmask <= 1'b0;
    else if (wr_take & hit(wb_adr_i, vpic_pkg::vpic_general_mask))
      gmask <= wb_dat_i[vpic_pkg::vpic_gm_bit];
  end

  // mode and vector arrays, one word each per source
  // source zero keeps a priority field that the resolver never reads
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int i = 0; i < n; i++)
      begin
        pri_field[i] <= vpic_pkg::vpic_pri_reset;
        trigger_type_field[i] <= vpic_pkg::vpic_trig_reset;
        source_vector_reg[i] <= vpic_pkg::vpic_word_zero;
      end
    end
    else if (wr_take & in_region(wb_adr_i, vpic_pkg::vpic_mode_base))
    begin
      pri_field[wb_adr_i[6:2]] <= wb_dat_i[vpic_pkg::vpic_pri_msb:
                                           vpic_pkg::vpic_pri_lsb];
      trigger_type_field[wb_adr_i[6:2]] <=
        wb_dat_i[vpic_pkg::vpic_trig_msb:vpic_pkg::vpic_trig_lsb];
    end
    else if (wr_take & in_region(wb_adr_i, vpic_pkg::vpic_vect_base))
      source_vector_reg[wb_adr_i[6:2]] <= wb_dat_i;
  end

  // current interrupt is the top of the nesting stack
  // an empty stack reads as source zero at level zero
  assign cur_num = (depth == vpic_pkg::vpic_depth_zero) ? 5'h00 :
                   stk_num[3'(depth - vpic_pkg::vpic_depth_one)];
  assign cur_pri = (depth == vpic_pkg::vpic_depth_zero) ? 3'h0 :
                   stk_pri[3'(depth - vpic_pkg::vpic_depth_one)];

  // resolver over sources 1..31, forced and masked ones left out;
  // scan from high index down so that ties keep the lowest number
  // one flat comparison chain: slow, but small and within one cycle
  always_comb
  begin
    best_valid = 1'b0;
    best_num = 5'h00;
    best_pri = 3'h0;
    for (int i = n - 1; i >= 1; i--)
    begin
      if (pending[i] & mask_reg[i] & ~force_reg[i])
      begin
        if (!best_valid || pri_field[i] >= best_pri)
        begin
          best_valid = 1'b1;
          best_num = 5'(i);
          best_pri = pri_field[i];
        end
      end
    end
  end

  // normal request only above the current level while nested
  // equal levels wait for the end-of-service write
  assign normal_cond = best_valid &
                       ((depth == vpic_pkg::vpic_depth_zero) |
                        (best_pri > cur_pri));
  // fast request: source zero or any forced source
  assign fast_cond = (pending[0] & mask_reg[0]) |
                     (|(pending & mask_reg & force_reg));

  // nesting stack: vector read pushes, end of service pops;
  // push raises the level, which drops the normal request
  // eight levels of priority need at most eight nestings
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      depth <= vpic_pkg::vpic_depth_zero;
      for (int i = 0; i < vpic_depth_arr; i++)
      begin
        stk_num[i] <= 5'h00;
        stk_pri[i] <= 3'h0;
      end
    end
    else if (do_push)
    begin
      stk_num[3'(depth)] <= best_num;
      stk_pri[3'(depth)] <= best_pri;
      depth <= depth + vpic_pkg::vpic_depth_one;
    end
    else if (wr_eos & (depth != vpic_pkg::vpic_depth_zero))
      depth <= depth - vpic_pkg::vpic_depth_one;
  end

  // request outputs, held off by general mask, wake stays live;
  // no power control input exists, so clocks never stop here
  // wake skips the general mask so an idle core can sync on events
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      normal_request_out_n <= 1'b1;
      fast_request_out_n <= 1'b1;
      wake_out <= 1'b0;
    end
    else
    begin
      // a push this cycle lifts the level, so drop at once
      normal_request_out_n <= ~(normal_cond & ~gmask & ~rd_normal);
      fast_request_out_n <= ~(fast_cond & ~gmask);
      wake_out <= normal_cond | fast_cond;
    end
  end

  // read data mux
  // reads have no side effect here; those live in the take decode,
  // so a request held through its ack never repeats them
  always_comb
  begin
    next_rdata = vpic_pkg::vpic_word_zero;
    if (in_region(wb_adr_i, vpic_pkg::vpic_mode_base))
    begin
      next_rdata[vpic_pkg::vpic_pri_msb:vpic_pkg::vpic_pri_lsb] =
        pri_field[wb_adr_i[6:2]];
      next_rdata[vpic_pkg::vpic_trig_msb:vpic_pkg::vpic_trig_lsb] =
        trigger_type_field[wb_adr_i[6:2]];
    end
    else if (in_region(wb_adr_i, vpic_pkg::vpic_vect_base))
      next_rdata = source_vector_reg[wb_adr_i[6:2]];
    else if (hit(wb_adr_i, vpic_pkg::vpic_normal_vector))
    begin
      // nothing eligible: return zero, no push
      if (normal_cond)
        next_rdata = source_vector_reg[best_num];
    end
    else if (hit(wb_adr_i, vpic_pkg::vpic_fast_vector))
      next_rdata = source_vector_reg[0];
    else if (hit(wb_adr_i, vpic_pkg::vpic_current_number))
      next_rdata[4:0] = cur_num;
    else if (hit(wb_adr_i, vpic_pkg::vpic_pending))
      next_rdata = pending;
    else if (hit(wb_adr_i, vpic_pkg::vpic_mask))
      next_rdata = mask_reg;
    else if (hit(wb_adr_i, vpic_pkg::vpic_core_status))
    begin
      next_rdata[vpic_pkg::vpic_cs_fast] = ~fast_request_out_n;
      next_rdata[vpic_pkg::vpic_cs_normal] = ~normal_request_out_n;
    end
    else if (hit(wb_adr_i, vpic_pkg::vpic_general_mask))
      next_rdata[vpic_pkg::vpic_gm_bit] = gmask;
    else if (hit(wb_adr_i, vpic_pkg::vpic_force_status))
      next_rdata = force_reg;
  end

  // wishbone answer: ack one cycle after take, unmapped reads zero
  // the ~ack term in take keeps a held request from a second take
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= take;
  end

  // registered read data, captured with the take
  // held between reads so a slow master still finds it
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      wb_dat_o <= vpic_pkg::vpic_word_zero;
    else if (rd_take)
      wb_dat_o <= next_rdata;
  end
endmodule
`default_nettype wire

// >>> vpic_pkg.sv
// Purpose: constants for the vectored priority interrupt controller
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: all offsets are byte addresses of aligned words
// What this block does
// - source zero is the fast request input
// - source one is OR of system lines
// - sources two to thirty-one from peripherals/pins
// - always clocked, no power gating
// - either request output raises the wake output
// - general mask wakes without asserting requests
// - per-source trigger type selects level or edge
// - high, low, rising and falling triggers
// - enable/disable commands, readable mask register
// - set/clear commands act on edge sources only
// - vector read clears current source edge memory
// - no vector-read clear for fast-forced sources
// - fast vector read clears source zero memory
// - pending register shows activity regardless of mask
// - current number and core status registers
// - pin routing adds no latency difference
// - priority resolver drives normal request, excluding forced
// - three-bit priority per source, seven highest
// - current interrupt chosen at vector read
// - equal priority: lowest source number wins
// - nested request only for strictly higher priority
// - vector read pushes, end-of-service write pops
// - vector read deasserts the normal request
// - vector read returns current source vector
package vpic_pkg;
  localparam int unsigned vpic_nsrc = 32;
  localparam int unsigned vpic_nsys = 4; // system peripheral lines
  localparam int unsigned vpic_depth = 8; // nesting stack depth
  // region bases for the per-source arrays
  localparam logic [9:0] vpic_mode_base = 10'h000;
  localparam logic [9:0] vpic_vect_base = 10'h080;
  // single registers
  localparam logic [9:0] vpic_normal_vector = 10'h100;
  localparam logic [9:0] vpic_fast_vector = 10'h104;
  localparam logic [9:0] vpic_current_number = 10'h108;
  localparam logic [9:0] vpic_pending = 10'h10c;
  localparam logic [9:0] vpic_mask = 10'h110;
  localparam logic [9:0] vpic_core_status = 10'h114;
  localparam logic [9:0] vpic_enable_cmd = 10'h120;
  localparam logic [9:0] vpic_disable_cmd = 10'h124;
  localparam logic [9:0] vpic_clear_cmd = 10'h128;
  localparam logic [9:0] vpic_set_cmd = 10'h12c;
  localparam logic [9:0] vpic_end_of_service = 10'h130;
  localparam logic [9:0] vpic_general_mask = 10'h138;
  localparam logic [9:0] vpic_force_enable = 10'h140;
  localparam logic [9:0] vpic_force_disable = 10'h144;
  localparam logic [9:0] vpic_force_status = 10'h148;
  // mode register fields
  localparam int unsigned vpic_pri_lsb = 0;
  localparam int unsigned vpic_pri_msb = 2;
  localparam int unsigned vpic_trig_lsb = 5;
  localparam int unsigned vpic_trig_msb = 6;
  // core status bits
  localparam int unsigned vpic_cs_fast = 0;
  localparam int unsigned vpic_cs_normal = 1;
  // general mask bit
  localparam int unsigned vpic_gm_bit = 1;
  // trigger type encodings
  typedef enum logic [1:0] {
    vpic_trig_low = 2'b00,
    vpic_trig_fall = 2'b01,
    vpic_trig_high = 2'b10,
    vpic_trig_rise = 2'b11
  } vpic_trig_t;
  localparam logic [2:0] vpic_pri_reset = 3'h0;
  localparam logic [1:0] vpic_trig_reset = 2'h0;
  localparam logic [31:0] vpic_word_zero = 32'h0000_0000;
  localparam logic [3:0] vpic_depth_zero = 4'h0;
  localparam logic [3:0] vpic_depth_one = 4'h1;
  localparam logic [3:0] vpic_depth_full = 4'h8;
endpackage

// >>> vpic_assertions.sv
// Purpose: port-level checks for the interrupt controller
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every vpic_top instance below the module
`timescale 1ns/10ps
`default_nettype none
module vpic_assertions
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // processor side
  input wire logic normal_request_out_n,
  input wire logic fast_request_out_n,
  input wire logic wake_out,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // request taken at this edge
  logic take;
  // normal vector read taken at this edge
  logic vec_rd;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign vec_rd = take && !wb_we_i &&
    wb_adr_i == vpic_pkg::vpic_normal_vector;
  chk_reset_quiet:
    assert property ($fell(srst) |-> normal_request_out_n &&
      fast_request_out_n && !wake_out && !wb_ack_o)
    else $error("outputs not idle after reset");
  chk_ack_next:
    assert property (take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause:
    assert property (wb_ack_o |-> $past(take))
    else $error("ack without a request");
  chk_wake_normal:
    assert property (!normal_request_out_n |-> wake_out)
    else $error("normal request without wake");
  chk_wake_fast:
    assert property (!fast_request_out_n |-> wake_out)
    else $error("fast request without wake");
  chk_vector_drop:
    assert property (vec_rd && !normal_request_out_n |->
      ##[1:2] normal_request_out_n)
    else $error("vector read left request asserted");
  chk_data_hold:
    assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data changed without ack");
  // main scenarios reached
  cover property (!normal_request_out_n);
  cover property (!fast_request_out_n);
  cover property (vec_rd && !normal_request_out_n);
endmodule
bind vpic_top vpic_assertions u_vpic_assertions
(
  .clk_sys(clk_sys), .srst(srst),
  .normal_request_out_n(normal_request_out_n),
  .fast_request_out_n(fast_request_out_n), .wake_out(wake_out),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);
`default_nettype wire

// >>> vpic_core_model.sv
// Purpose: processor core stand-in that idles and wakes
// Assumes: request lines active low as the controller drives them
// Notes: idle entry is commanded by the bench only
`timescale 1ns/10ps
`default_nettype none
module vpic_core_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // lines from the controller
  input wire logic normal_request_out_n,
  input wire logic fast_request_out_n,
  input wire logic wake_out,
  // idle control and state
  input wire logic sleep_req,
  output logic asleep
);
  // wake beats a new idle entry, so no event is lost
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      asleep <= 1'b0;
    else if (!normal_request_out_n || !fast_request_out_n)
      asleep <= 1'b0;
    else if (wake_out)
      asleep <= 1'b0;
    else if (sleep_req)
      asleep <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: sources driven on the clock, master waits on ack
// Notes: a small resolver model predicts each vector and level
`timescale 1ns/10ps
`default_nettype none
module tb;
  // stimulus and responses
  logic clk_sys, srst, fast_request_input, sleep_req, asleep;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic normal_request_out_n, fast_request_out_n, wake_out;
  logic [3:0] system_lines;
  logic [31:2] external_request_inputs;
  logic [9:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, m;
  int miscompares, compares;
  // model: priorities, vectors, pending, mask, nesting stack
  logic [2:0] pri [32];
  logic [31:0] vec [32];
  logic [31:0] pend, mask;
  int stk [$];
  vpic_top u_vpic_top
  (
    .clk_sys(clk_sys), .srst(srst),
    .fast_request_input(fast_request_input), .system_lines(system_lines),
    .external_request_inputs(external_request_inputs),
    .normal_request_out_n(normal_request_out_n),
    .fast_request_out_n(fast_request_out_n), .wake_out(wake_out),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
  );
  vpic_core_model u_vpic_core_model
  (
    .clk_sys(clk_sys), .srst(srst),
    .normal_request_out_n(normal_request_out_n),
    .fast_request_out_n(fast_request_out_n), .wake_out(wake_out),
    .sleep_req(sleep_req), .asleep(asleep)
  );
  // 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  // one classic cycle; a missing ack counts as a mismatch
  task automatic bus(input logic we, input logic [9:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_sys);
    while (wb_ack_o !== 1'b1 && ++n < 20);
    if (n >= 20)
    begin
      miscompares++;
      $display("wrong value at %0t: no ack", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // one-cycle high pulse on the chosen sources
  task automatic pulse(input logic [31:0] s);
    pend = pend | s;
    fast_request_input <= s[0];
    system_lines <= s[1] ? 4'($urandom_range(15, 1)) : 4'h0;
    external_request_inputs <= s[31:2];
    @(posedge clk_sys);
    fast_request_input <= 1'b0;
    system_lines <= 4'h0;
    external_request_inputs <= '0;
    repeat (3) @(posedge clk_sys);
  endtask
  // highest level wins, lowest number on ties, above current level
  function automatic int pick();
    int b;
    b = -1;
    for (int i = 1; i < 32; i++)
      if (pend[i] && mask[i] && (b < 0 || pri[i] > pri[b]))
        b = i;
    if (b >= 0 && stk.size() > 0 && pri[b] <= pri[stk[$]])
      b = -1;
    return b;
  endfunction
  task automatic serve();
    int s;
    s = pick();
    chk({31'h0, normal_request_out_n}, {31'h0, s < 0}, "request");
    rd(vpic_pkg::vpic_normal_vector);
    chk(q, (s < 0) ? 32'h0 : vec[s], "vector");
    if (s >= 0)
    begin
      pend[s] = 1'b0;
      stk.push_back(s);
    end
    rd(vpic_pkg::vpic_pending);
    chk(q, pend, "auto clear");
    rd(vpic_pkg::vpic_current_number);
    chk(q, 32'(stk.size() > 0 ? stk[$] : 0), "current");
  endtask
  task automatic done();
    wr(vpic_pkg::vpic_end_of_service, 32'h0);
    if (stk.size() > 0)
      void'(stk.pop_back());
  endtask
  // hang guard, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    complete_run();
  end
  initial
  begin
    srst = 1'b1;
    fast_request_input = 1'b0;
    sleep_req = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    system_lines = 4'h0;
    external_request_inputs = '0;
    wb_adr_i = 10'h000;
    wb_dat_i = 32'h0;
    pend = 32'h0;
    void'($urandom(32'ha1618794));
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rd(vpic_pkg::vpic_mask);
    chk(q, 32'h0, "mask reset");
    rd(vpic_pkg::vpic_pending);
    chk(q, 32'hffff_ffff, "low level");
    $display("test reset done");
    for (int i = 0; i < 32; i++)
    begin
      pri[i] = 3'($urandom);
      vec[i] = $urandom;
      wr(vpic_pkg::vpic_mode_base + 10'(4 * i),
        {25'h0, vpic_pkg::vpic_trig_rise, 2'h0, pri[i]});
      wr(vpic_pkg::vpic_vect_base + 10'(4 * i), vec[i]);
    end
    mask = 32'hffff_ffdf;
    wr(vpic_pkg::vpic_enable_cmd, 32'hffff_ffff);
    wr(vpic_pkg::vpic_disable_cmd, 32'h0000_0020);
    rd(vpic_pkg::vpic_mask);
    chk(q, mask, "mask");
    $display("test config done");
    m = $urandom & 32'hffff_fffe;
    pulse(m);
    rd(vpic_pkg::vpic_pending);
    chk(q, pend, "burst");
    while (pick() >= 0)
    begin
      serve();
      done();
    end
    chk({31'h0, normal_request_out_n}, 32'h1, "quiet");
    $display("test burst done");
    wr(vpic_pkg::vpic_clear_cmd, 32'h0000_0020);
    pend[5] = 1'b0;
    wr(vpic_pkg::vpic_set_cmd, 32'h0000_0080);
    pend[7] = 1'b1;
    wr(vpic_pkg::vpic_mode_base + 10'h024,
      {25'h0, vpic_pkg::vpic_trig_high, 5'h0});
    wr(vpic_pkg::vpic_set_cmd, 32'h0000_0200);
    rd(vpic_pkg::vpic_pending);
    chk(q, pend, "set clear");
    serve();
    done();
    $display("test commands done");
    pri[2] = 3'h1;
    pri[3] = 3'h6;
    pri[4] = 3'h6;
    for (int i = 2; i < 5; i++)
      wr(vpic_pkg::vpic_mode_base + 10'(4 * i),
        {25'h0, vpic_pkg::vpic_trig_rise, 2'h0, pri[i]});
    pulse(32'h4);
    serve();
    pulse(32'h8);
    serve();
    pulse(32'h10);
    chk({31'h0, normal_request_out_n}, 32'h1, "equal held");
    serve();
    done();
    serve();
    done();
    done();
    rd(vpic_pkg::vpic_current_number);
    chk(q, 32'h0, "stack empty");
    $display("test nesting done");
    pulse(32'h1);
    chk({31'h0, fast_request_out_n}, 32'h0, "fast");
    rd(vpic_pkg::vpic_core_status);
    chk(q, 32'h1, "core status");
    rd(vpic_pkg::vpic_fast_vector);
    chk(q, vec[0], "fast vector");
    pend[0] = 1'b0;
    rd(vpic_pkg::vpic_pending);
    chk(q, pend, "fast clear");
    chk({31'h0, fast_request_out_n}, 32'h1, "fast off");
    wr(vpic_pkg::vpic_force_enable, 32'h0010_0000);
    pulse(32'h0010_0000);
    chk({31'h0, fast_request_out_n}, 32'h0, "forced fast");
    chk({31'h0, normal_request_out_n}, 32'h1, "forced off");
    rd(vpic_pkg::vpic_force_status);
    chk(q, 32'h0010_0000, "force status");
    rd(vpic_pkg::vpic_normal_vector);
    chk(q, 32'h0, "forced vector");
    rd(vpic_pkg::vpic_pending);
    chk(q, pend, "forced kept");
    wr(vpic_pkg::vpic_clear_cmd, 32'h0010_0000);
    wr(vpic_pkg::vpic_force_disable, 32'h0010_0000);
    pend[20] = 1'b0;
    rd(vpic_pkg::vpic_pending);
    chk(q, pend, "forced cleared");
    $display("test fast done");
    wr(vpic_pkg::vpic_general_mask, 32'h2);
    sleep_req <= 1'b1;
    @(posedge clk_sys);
    sleep_req <= 1'b0;
    @(posedge clk_sys);
    chk({31'h0, asleep}, 32'h1, "idle");
    pulse(32'h0004_0000);
    chk({31'h0, normal_request_out_n}, 32'h1, "masked");
    chk({31'h0, asleep}, 32'h0, "woken");
    wr(vpic_pkg::vpic_general_mask, 32'h0);
    serve();
    done();
    $display("test wake done");
    complete_run();
  end
endmodule
`default_nettype wire
